// *** bench/ive_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========
// byte memory and stack behind the entry unit
module ive_mem_model
  import ive_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // memory port
  input  wire ive_mem_t   mem_o,
  output logic            mem_ack,
  output logic [7:0]      mem_rdata,
  // wait states before each ack
  input  wire logic [1:0] wait_n
);
  logic [7:0]  m [logic [21:0]];
  logic [7:0]  wq [$];
  logic [21:0] rq [$];
  logic [1:0]  cnt_q;
  logic [7:0]  last_q;
  assign mem_ack = mem_o.req && cnt_q == wait_n;
  // off an ack the bus shows the inverse byte, so late sampling fails
  always_comb begin
    mem_rdata = ~last_q;
    if (mem_ack) begin
      mem_rdata = m.exists(mem_o.addr) ? m[mem_o.addr] : 8'hEE;
    end
  end
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 2'h0;
      last_q <= 8'h00;
    end else if (mem_ack) begin
      cnt_q <= 2'h0;
      last_q <= mem_rdata;
      if (mem_o.we) begin
        m[mem_o.addr] = mem_o.wdata;
        wq.push_back(mem_o.wdata);
      end else begin
        rq.push_back(mem_o.addr);
      end
    end else if (mem_o.req) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// *** bench/ive_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========
// port checker for the entry unit
module ive_properties
  import ive_pkg::*;
(
  // clock and reset
  input wire logic     clk_sys,
  input wire logic     arst_n,
  // requests
  input wire logic     div0_trap,
  input wire logic     iret_req,
  // memory port
  input wire ive_mem_t mem_o,
  input wire logic     mem_ack,
  // results
  input wire logic     ctx_load,
  input wire logic     global_irq_enable,
  input wire logic     busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_boot_read: assert property ($rose(arst_n) |-> ##[0:3]
    (mem_o.req && !mem_o.we && mem_o.addr == 22'h000000))
    else $error("boot read missing");
  a_req_hold: assert property (mem_o.req && !mem_ack |=> $stable(mem_o))
    else $error("request changed before ack");
  a_req_busy: assert property (mem_o.req |-> busy)
    else $error("memory request while idle");
  a_load_pulse: assert property (ctx_load |=> !ctx_load)
    else $error("load longer than one cycle");
  a_load_idle: assert property (ctx_load |=> !busy)
    else $error("busy after load");
  a_load_read: assert property (ctx_load |->
    $past(mem_ack) && !$past(mem_o.we))
    else $error("load not after read");
  a_trap_push: assert property (!busy && div0_trap && !iret_req
    |=> mem_o.req && mem_o.we)
    else $error("trap not pushing");
  a_iret_pop: assert property (!busy && iret_req
    |=> mem_o.req && !mem_o.we)
    else $error("return not popping");
  a_entry_mask: assert property (!busy && global_irq_enable
    && !div0_trap && !iret_req ##1 mem_o.req && mem_o.we
    |-> !global_irq_enable)
    else $error("enable kept during entry");
  c_trap: cover property (!busy && div0_trap);
  c_iret: cover property (!busy && iret_req);
  c_wait: cover property (mem_o.req && !mem_ack);
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ive_pkg::*;
  // ========
  // wiring
  logic [7:0]  ext_pin, ext_edge_rising, peripheral_vector_register;
  logic [7:0]  cpu_flags_register, mem_rdata, ext_pending;
  logic        clk_sys, arst_n, nmi_pin, wdg_req, top_sel_wdg, per_req;
  logic        div0_trap, iret_req, ei_req, save_code_segment_enable;
  logic        mem_ack, ctx_load, global_irq_enable, use_isp_as_code, busy;
  logic [1:0]  per_src, wait_n;
  logic [2:0]  ext_win;
  logic [5:0]  interrupt_segment_pointer;
  logic [15:0] core_pc;
  ive_mem_t    mem_o;
  ive_ctx_t    ctx_o;
  int          n_errors, checked, cyc;
  ive_core uut (.*);
  ive_mem_model mem (.*);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      end_sim();
    end
  end
  // ========
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_load();
    int k;
    for (k = 0; k < 300 && ctx_load !== 1'b1; k++) begin
      step(1);
    end
    chk(k < 300, 1'b1);
  endtask
  // requests are refused while busy, so wait for the unit to go idle
  task automatic wait_idle();
    int k;
    for (k = 0; k < 300 && busy !== 1'b0; k++) begin
      step(1);
    end
    chk(k < 300, 1'b1);
  endtask
  task automatic enter(input int kind, input logic [21:0] va, input int nw);
    mem.m[va] = va[7:0] ^ 8'h3C;
    mem.m[va + 22'h1] = va[7:0] ^ 8'hC3;
    mem.wq.delete();
    mem.rq.delete();
    wait_idle();
    case (kind)
      0: div0_trap = 1'b1;
      1: nmi_pin = 1'b1;
      2: wdg_req = 1'b1;
      3: per_req = 1'b1;
      default: ext_win = va[2:0];
    endcase
    step(1);
    {div0_trap, nmi_pin, wdg_req} = 3'h0;
    wait_load();
    per_req = 1'b0;
    chk(ctx_o.pc, {va[7:0] ^ 8'h3C, va[7:0] ^ 8'hC3});
    chk(mem.rq.size(), 2);
    chk(mem.rq[0], va);
    chk(mem.rq[1], va + 22'h1);
    chk(mem.wq.size(), nw);
    chk({mem.wq[1], mem.wq[0]}, core_pc);
    chk(mem.wq[nw-1], nw > 2 ? cpu_flags_register : core_pc[15:8]);
    chk(global_irq_enable, 1'b0);
  endtask
  task automatic ret(input int nr);
    mem.rq.delete();
    wait_idle();
    iret_req = 1'b1;
    step(1);
    iret_req = 1'b0;
    wait_load();
    chk(ctx_o.pc, core_pc);
    chk(ctx_o.flags, cpu_flags_register);
    chk(mem.rq.size(), nr);
    step(2);
    chk(global_irq_enable, 1'b1);
  endtask
  // ========
  // scenarios
  task automatic t_boot();
    mem.m[22'h000000] = 8'h3C;
    mem.m[22'h000001] = 8'hC3;
    step(4);
    arst_n = 1'b1;
    wait_load();
    chk(ctx_o.pc, 16'h3CC3);
    chk(mem.rq[1], 22'h000001);
    chk(ctx_o.cseg, 6'h00);
    // enable first, so that the trap entry has an enable to clear
    wait_idle();
    ei_req = 1'b1;
    step(1);
    ei_req = 1'b0;
    chk(global_irq_enable, 1'b1);
  endtask
  task automatic t_trap();
    enter(0, 22'h000002, 2);
    chk(ctx_o.cseg, 6'h00);
  endtask
  task automatic t_top();
    for (int s = 0; s < 2; s++) begin
      top_sel_wdg = s[0];
      wait_n = s[0] ? 2'h3 : 2'h0;
      enter(s + 1, {interrupt_segment_pointer, 16'h0004}, 4);
      chk(mem.wq[2][5:0], 6'h00);
      chk(ctx_o.cseg, interrupt_segment_pointer);
      ret(4);
      chk(ctx_o.cseg, 6'h00);
    end
  endtask
  task automatic t_per();
    save_code_segment_enable = 1'b0;
    for (int s = 0; s < 4; s++) begin
      per_src = s[1:0];
      wait_n = s[1:0];
      enter(3, {interrupt_segment_pointer, 8'h00, 8'hA4 | s[7:0]}, 3);
      chk(use_isp_as_code, 1'b1);
      per_req = 1'b1;
      step(6);
      chk(busy, 1'b0);
      per_req = 1'b0;
      ret(3);
      chk(use_isp_as_code, 1'b0);
    end
  endtask
  task automatic t_ext();
    ext_win = 3'h7;
    ext_edge_rising[5] = 1'b0;
    ext_pin[2] = 1'b1;
    ext_pin[5] = 1'b1;
    step(5);
    chk(ext_pending, 8'h04);
    ext_pin[5] = 1'b0;
    step(5);
    chk(ext_pending, 8'h24);
    enter(4, {interrupt_segment_pointer, 8'h00, 8'hA2}, 3);
    chk(ext_pending, 8'h20);
    ret(3);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    {ext_pin, nmi_pin, wdg_req, top_sel_wdg, per_req, per_src} = 14'h0000;
    {div0_trap, iret_req, ei_req, wait_n, ext_win} = 8'h00;
    ext_edge_rising = 8'hFF;
    peripheral_vector_register = 8'hA7;
    save_code_segment_enable = 1'b1;
    interrupt_segment_pointer = 6'h15;
    core_pc = 16'h1234;
    cpu_flags_register = 8'h5A;
    arst_n = 1'b0;
    t_boot();
    t_trap();
    t_top();
    t_per();
    t_ext();
    end_sim();
  end
endmodule
bind ive_core ive_properties chk (.*);
`default_nettype wire

// *** hw/ive_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ive_params.svh"
// Contract
// [RULE1] vector table is first 256 bytes of interrupt segment, 8-bit index
// [RULE2] reset vector read from physical bytes 000000h and 000001h
// [RULE3] top-level vector read from 0004h/0005h of interrupt segment
// [RULE4] peripheral vector: upper bits software base, lower bits hardware source
// [RULE5] one vector register serves several channels via low bits
// [RULE6] divide-by-zero vectors via 0002h/0003h of current code segment
// [RULE7] divide-by-zero trap does not push flags
// [RULE8] one control bit selects whether code segment is saved
// [RULE9] bit clear: push PC and flags, run routine in interrupt segment
// [RULE10] bit clear: routine code confined to one 64K segment
// [RULE11] bit set: push old code segment too, load it from interrupt segment
// [RULE12] bit set: interrupt return also restores code segment
// [RULE13] up to eight external channels, each with programmable edge
// [RULE14] top-level channel from non-maskable pin or timer/watchdog
// [RULE15] entry only when enabled and a request wins priority (divide-by-zero trap and top level enter regardless of the enable)
// [RULE16] entry clears global interrupt enable first
// [RULE17] push order: PC low, PC high, code segment if saved, flags
// [RULE18] then load PC with 16-bit table entry
// [RULE19] return pops flags, code segment, PC high, PC low, re-enables
// [RULE20] fetch address is interrupt segment concatenated with vector
module ive_core
  import ive_pkg::*;
#(
  parameter int NUM_EXT  = `IVE_NUM_EXT,
  parameter int LOW_BITS = 2
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  // external pins and top-level sources
  input  wire logic [NUM_EXT-1:0]  ext_pin,
  input  wire logic [NUM_EXT-1:0]  ext_edge_rising,
  input  wire logic                nmi_pin,
  input  wire logic                wdg_req,
  input  wire logic                top_sel_wdg,
  // peripheral request, already arbitrated
  input  wire logic                per_req,
  input  wire logic [7:0]          peripheral_vector_register,
  input  wire logic [LOW_BITS-1:0] per_src,
  input  wire logic [2:0]          ext_win,
  // core side
  input  wire logic                div0_trap,
  input  wire logic                iret_req,
  input  wire logic                ei_req,
  input  wire logic                save_code_segment_enable,
  input  wire logic [5:0]          interrupt_segment_pointer,
  input  wire logic [15:0]         core_pc,
  input  wire logic [7:0]          cpu_flags_register,
  // memory / stack port
  output ive_mem_t                 mem_o,
  input  wire logic                mem_ack,
  input  wire logic [7:0]          mem_rdata,
  // results
  output ive_ctx_t                 ctx_o,
  output logic                     ctx_load,
  output logic                     global_irq_enable,
  output logic                     use_isp_as_code,
  output logic [NUM_EXT-1:0]       ext_pending,
  output logic                     busy
);
  // =========================================================
  // pin synchronisers and edge detect
  logic [NUM_EXT:0] s1_q, s2_q, s3_q;
  logic [NUM_EXT:0] pin_in;
  assign pin_in = {nmi_pin, ext_pin};
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic [NUM_EXT-1:0] ext_hit;
  logic [NUM_EXT-1:0] pend_d, pend_q;
  logic               clr_ext;
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_ext
      // edge chosen per channel by software
      assign ext_hit[g] = ext_edge_rising[g] ? (s2_q[g] & ~s3_q[g])
                                             : (~s2_q[g] & s3_q[g]); // see [RULE13]
    end
  endgenerate
  logic nmi_hit;
  assign nmi_hit = s2_q[NUM_EXT] & ~s3_q[NUM_EXT];

  // =========================================================
  // pending flags: a new edge wins over the acknowledge clear
  logic top_d, top_q;
  logic clr_top;
  always_comb begin
    pend_d = pend_q;
    if (clr_ext) begin
      pend_d[ext_win] = 1'b0;
    end
    pend_d = pend_d | ext_hit;
    top_d  = top_q;
    if (clr_top) begin
      top_d = 1'b0;
    end
    if (top_sel_wdg ? wdg_req : nmi_hit) begin // see [RULE14]
      top_d = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= '0;
      top_q  <= 1'b0;
    end else begin
      pend_q <= pend_d;
      top_q  <= top_d;
    end
  end

  // =========================================================
  // vector formation
  logic [7:0] per_vec;
  ive_vec_form #(.LOW_BITS(LOW_BITS)) u_vec (
    .base_i (peripheral_vector_register),
    .src_i  (per_src),
    .vec_o  (per_vec)
  );

  // =========================================================
  // entry / exit sequencer
  ive_state_t st_d, st_q;
  ive_mem_t   mem_d, mem_q;
  ive_ctx_t   ctx_d, ctx_q, sav_d, sav_q;
  logic       ien_d, ien_q, ld_d, ld_q, isp_d, isp_q;
  logic       save_d, save_q, trap_d, trap_q;
  logic [21:0] vaddr_d, vaddr_q;
  logic [21:0] sp_d, sp_q;
  logic        go;

  // trap and top level are not gated by the enable; others are
  assign go = div0_trap | top_q | (ien_q & (per_req | pend_q[ext_win])); // see [RULE15]

  always_comb begin
    st_d    = st_q;
    mem_d   = mem_q;
    ctx_d   = ctx_q;
    sav_d   = sav_q;
    ien_d   = ien_q;
    ld_d    = 1'b0;
    isp_d   = isp_q;
    save_d  = save_q;
    trap_d  = trap_q;
    vaddr_d = vaddr_q;
    sp_d    = sp_q;
    clr_ext = 1'b0;
    clr_top = 1'b0;
    case (st_q)
      IVE_BOOT0: begin
        mem_d = '{req: 1'b1, we: 1'b0, addr: `IVE_RESET_VEC_LO, wdata: 8'h00}; // see [RULE2]
        st_d  = IVE_BOOT1;
      end
      IVE_BOOT1: begin
        if (mem_ack && mem_q.addr == `IVE_RESET_VEC_LO) begin
          ctx_d.pc[15:8] = mem_rdata;
          mem_d.addr     = `IVE_RESET_VEC_HI;
        end else if (mem_ack) begin
          ctx_d.pc[7:0] = mem_rdata;
          ctx_d.cseg    = `IVE_CSEG_RST;
          mem_d.req     = 1'b0;
          ld_d          = 1'b1;
          st_d          = IVE_DONE;
        end
      end
      IVE_IDLE: begin
        if (iret_req) begin
          save_d = save_code_segment_enable;
          mem_d  = '{req: 1'b1, we: 1'b0, addr: sp_q, wdata: 8'h00};
          sp_d   = sp_q + 22'd1;
          st_d   = IVE_POPF; // see [RULE19]
        end else if (go) begin
          ien_d  = 1'b0; // see [RULE16]
          save_d = save_code_segment_enable & ~div0_trap; // see [RULE8]
          trap_d = div0_trap;
          sav_d  = '{pc: core_pc, flags: cpu_flags_register, cseg: ctx_q.cseg};
          if (div0_trap) begin
            vaddr_d = {ctx_q.cseg, 8'h00, `IVE_DIV0_VEC_LO}; // see [RULE6]
          end else if (top_q) begin
            clr_top = 1'b1;
            vaddr_d = {interrupt_segment_pointer, 8'h00, `IVE_TOP_VEC_LO}; // see [RULE3]
          end else if (per_req) begin
            vaddr_d = {interrupt_segment_pointer, 8'h00, per_vec}; // see [RULE1] see [RULE20]
          end else begin
            clr_ext = 1'b1;
            vaddr_d = {interrupt_segment_pointer, 8'h00, per_vec[7:4], 1'b0, ext_win};
          end
          sp_d  = sp_q - 22'd1;
          mem_d = '{req: 1'b1, we: 1'b1, addr: sp_q - 22'd1, wdata: core_pc[7:0]}; // see [RULE17]
          st_d  = IVE_PUSHL;
        end
      end
      IVE_PUSHL: if (mem_ack) begin
        sp_d        = sp_q - 22'd1;
        mem_d.addr  = sp_q - 22'd1;
        mem_d.wdata = sav_q.pc[15:8];
        st_d        = IVE_PUSHH;
      end
      IVE_PUSHH: if (mem_ack) begin
        if (save_q) begin
          sp_d        = sp_q - 22'd1;
          mem_d.addr  = sp_q - 22'd1;
          mem_d.wdata = {2'b00, sav_q.cseg}; // see [RULE11]
          st_d        = IVE_PUSHC;
        end else if (trap_q) begin
          mem_d = '{req: 1'b1, we: 1'b0, addr: vaddr_q, wdata: 8'h00}; // see [RULE7]
          st_d  = IVE_VECL;
        end else begin
          sp_d        = sp_q - 22'd1;
          mem_d.addr  = sp_q - 22'd1;
          mem_d.wdata = sav_q.flags; // see [RULE9]
          st_d        = IVE_PUSHF;
        end
      end
      IVE_PUSHC: if (mem_ack) begin
        sp_d        = sp_q - 22'd1;
        mem_d.addr  = sp_q - 22'd1;
        mem_d.wdata = sav_q.flags;
        st_d        = IVE_PUSHF;
      end
      IVE_PUSHF: if (mem_ack) begin
        mem_d = '{req: 1'b1, we: 1'b0, addr: vaddr_q, wdata: 8'h00};
        st_d  = IVE_VECL;
      end
      IVE_VECL: if (mem_ack) begin
        ctx_d.pc[15:8] = mem_rdata; // see [RULE18]
        mem_d.addr     = vaddr_q + 22'd1;
        st_d           = IVE_VECH;
      end
      IVE_VECH: if (mem_ack) begin
        ctx_d.pc[7:0] = mem_rdata;
        ctx_d.flags   = sav_q.flags;
        // without saving, the segment stays; outside a trap the core runs from isp
        ctx_d.cseg = save_q ? interrupt_segment_pointer : sav_q.cseg; // see [RULE11]
        isp_d      = ~save_q & ~trap_q; // see [RULE9] see [RULE10]
        mem_d.req  = 1'b0;
        ld_d       = 1'b1;
        st_d       = IVE_DONE;
      end
      IVE_POPF: if (mem_ack) begin
        ctx_d.flags = mem_rdata;
        mem_d.addr  = sp_q;
        sp_d        = sp_q + 22'd1;
        st_d        = save_q ? IVE_POPC : IVE_POPH;
      end
      IVE_POPC: if (mem_ack) begin
        ctx_d.cseg = mem_rdata[5:0]; // see [RULE12]
        mem_d.addr = sp_q;
        sp_d       = sp_q + 22'd1;
        st_d       = IVE_POPH;
      end
      IVE_POPH: if (mem_ack) begin
        ctx_d.pc[15:8] = mem_rdata;
        mem_d.addr     = sp_q;
        sp_d           = sp_q + 22'd1;
        st_d           = IVE_POPL;
      end
      IVE_POPL: if (mem_ack) begin
        ctx_d.pc[7:0] = mem_rdata;
        mem_d.req     = 1'b0;
        ien_d         = 1'b1; // see [RULE19]
        isp_d         = 1'b0;
        ld_d          = 1'b1;
        st_d          = IVE_DONE;
      end
      IVE_DONE: st_d = IVE_IDLE;
      default: st_d = IVE_IDLE;
    endcase
    if (ei_req && st_q == IVE_IDLE && !go) begin
      ien_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= IVE_BOOT0;
      mem_q   <= '0;
      ctx_q   <= '0;
      sav_q   <= '0;
      ien_q   <= 1'b0;
      ld_q    <= 1'b0;
      isp_q   <= 1'b0;
      save_q  <= 1'b0;
      trap_q  <= 1'b0;
      vaddr_q <= '0;
      sp_q    <= '0;
    end else begin
      st_q    <= st_d;
      mem_q   <= mem_d;
      ctx_q   <= ctx_d;
      sav_q   <= sav_d;
      ien_q   <= ien_d;
      ld_q    <= ld_d;
      isp_q   <= isp_d;
      save_q  <= save_d;
      trap_q  <= trap_d;
      vaddr_q <= vaddr_d;
      sp_q    <= sp_d;
    end
  end

  // =========================================================
  // outputs, all from flops
  logic busy_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b1;
    end else begin
      busy_q <= (st_d != IVE_IDLE);
    end
  end
  assign mem_o             = mem_q;
  assign ctx_o             = ctx_q;
  assign ctx_load          = ld_q;
  assign global_irq_enable = ien_q;
  assign use_isp_as_code   = isp_q;
  assign ext_pending       = pend_q;
  assign busy              = busy_q;
endmodule
`default_nettype wire

// *** hw/ive_params.svh ***
`ifndef IVE_PARAMS_SVH
`define IVE_PARAMS_SVH
// =========================================================
// address layout
`define IVE_TABLE_SIZE      256
`define IVE_RESET_VEC_LO    22'h000000
`define IVE_RESET_VEC_HI    22'h000001
`define IVE_TOP_VEC_LO      8'h04
`define IVE_TOP_VEC_HI      8'h05
`define IVE_DIV0_VEC_LO     8'h02
`define IVE_DIV0_VEC_HI     8'h03
// =========================================================
// reset values and channel count
`define IVE_CSEG_RST        6'h00
`define IVE_NUM_EXT         8
`endif

// *** hw/ive_pkg.sv ***
package ive_pkg;
  // =========================================================
  // types
  typedef enum logic [3:0] {
    IVE_BOOT0 = 4'h0,
    IVE_BOOT1 = 4'h1,
    IVE_IDLE  = 4'h3,
    IVE_PUSHL = 4'h2,
    IVE_PUSHH = 4'h6,
    IVE_PUSHC = 4'h7,
    IVE_PUSHF = 4'h5,
    IVE_VECL  = 4'h4,
    IVE_VECH  = 4'hC,
    IVE_POPF  = 4'hD,
    IVE_POPC  = 4'hF,
    IVE_POPH  = 4'hE,
    IVE_POPL  = 4'hA,
    IVE_DONE  = 4'h8
  } ive_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [21:0] addr;
    logic [7:0]  wdata;
  } ive_mem_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  flags;
    logic [5:0]  cseg;
  } ive_ctx_t;
endpackage

// *** hw/ive_vec_form.sv ***
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// forms one peripheral vector from base field and source bits
module ive_vec_form #(
  parameter int LOW_BITS = 2
) (
  // base and source
  input  wire logic [7:0]          base_i,
  input  wire logic [LOW_BITS-1:0] src_i,
  // vector
  output logic [7:0]               vec_o
);
  // software owns the upper bits, hardware the lower ones
  assign vec_o = {base_i[7:LOW_BITS], src_i}; // see [RULE4] see [RULE5]
endmodule
`default_nettype wire
